// [cbu_cond.sv]
/*
  Condition evaluator: decides from the branch kind and the status
  register whether a conditional branch is taken. Purely combinational.
  Assumes flag positions from cbu_pkg.
*/
`timescale 1ns/1ps
module cbu_cond (
  input  wire cbu_pkg::cbu_kind_t          kind_i,     // Branch kind
  input  wire logic [2:0]                  sel_i,      // Flag select
  input  wire logic [cbu_pkg::STATUS_W-1:0] status_i,  // Status register
  output logic                             taken_o     // Condition holds
);
  logic sel_bit;
  logic zero_f;
  logic carry_f;

  always_comb begin
    sel_bit = status_i[sel_i];
    zero_f  = status_i[cbu_pkg::FLAG_Z];
    carry_f = status_i[cbu_pkg::FLAG_C];
    case (kind_i)
      cbu_pkg::CBU_BRANCH_ON_BIT_SET:     taken_o = sel_bit;
      cbu_pkg::CBU_BRANCH_ON_BIT_CLEAR:   taken_o = !sel_bit;
      cbu_pkg::CBU_BRANCH_ON_EQUAL:       taken_o = zero_f;
      cbu_pkg::CBU_BRANCH_ON_NOT_EQUAL:   taken_o = !zero_f;
      cbu_pkg::CBU_BRANCH_ON_CARRY_SET:   taken_o = carry_f;
      cbu_pkg::CBU_BRANCH_ON_CARRY_CLEAR: taken_o = !carry_f;
      cbu_pkg::CBU_BRANCH_SAME_OR_HIGHER: taken_o = !carry_f;
      cbu_pkg::CBU_BRANCH_LOWER:          taken_o = carry_f;
      default:                            taken_o = 1'b0;
    endcase
  end

endmodule

// [cbu_pkg.sv]
/*
  Package for the conditional branch unit: branch kinds, flag positions,
  widths and cycle counts.
  Assumes an 8-bit status register and a word-addressed program counter.
*/
package cbu_pkg;

  // ==========================================================================
  // Widths and flag positions
  // ==========================================================================
  localparam int unsigned PC_W      = 13;
  localparam int unsigned DISP_W    = 7;
  localparam int unsigned STATUS_W  = 8;
  localparam int unsigned SEL_W     = 3;
  localparam logic [2:0]  FLAG_C    = 3'h0;
  localparam logic [2:0]  FLAG_Z    = 3'h1;
  localparam logic [12:0] PC_RESET  = 13'h0000;
  localparam logic [7:0]  STAT_RESET = 8'h00;

  // ==========================================================================
  // Cycle counts
  // ==========================================================================
  localparam int unsigned CYC_NOT_TAKEN = 1;
  localparam int unsigned CYC_TAKEN     = 2;

  // ==========================================================================
  // Branch kinds
  // ==========================================================================
  typedef enum logic [3:0] {
    CBU_NONE                  = 4'h0,
    CBU_BRANCH_ON_BIT_SET     = 4'h1,
    CBU_BRANCH_ON_BIT_CLEAR   = 4'h2,
    CBU_BRANCH_ON_EQUAL       = 4'h3,
    CBU_BRANCH_ON_NOT_EQUAL   = 4'h4,
    CBU_BRANCH_ON_CARRY_SET   = 4'h5,
    CBU_BRANCH_ON_CARRY_CLEAR = 4'h6,
    CBU_BRANCH_SAME_OR_HIGHER = 4'h7,
    CBU_BRANCH_LOWER          = 4'h8
  } cbu_kind_t;

  // Gray along idle -> redirect -> idle
  typedef enum logic [0:0] {
    CBU_IDLE     = 1'b0,
    CBU_REDIRECT = 1'b1
  } cbu_state_t;

endpackage

// [cbu_unit.sv]
/*
  Conditional branch unit: takes a decoded branch with its displacement,
  evaluates the condition and produces the next program counter.
  Assumes the decode stage holds off while busy_o is high and the core
  loads pc_o when pc_load_o pulses. Status register only observed.
*/
`timescale 1ns/1ps
module cbu_unit #(
  parameter int unsigned PC_W   = cbu_pkg::PC_W,
  parameter int unsigned DISP_W = cbu_pkg::DISP_W
) (
  input  wire logic                          mclk_i,     // Core clock
  input  wire logic                          nrst_i,     // Async reset, low
  input  wire logic                          valid_i,    // Branch issued
  input  wire cbu_pkg::cbu_kind_t            kind_i,     // Branch kind
  input  wire logic [2:0]                    sel_i,      // Flag select
  input  wire logic [DISP_W-1:0]             disp_i,     // Signed word offset
  input  wire logic [PC_W-1:0]               pc_i,       // Current pc
  input  wire logic [cbu_pkg::STATUS_W-1:0]  status_i,   // Status register
  output logic                               pc_load_o,  // Load pc_o
  output logic [PC_W-1:0]                    pc_o,       // Next pc
  output logic                               taken_o,    // Branch taken
  output logic                               done_o,     // Branch complete
  output logic                               busy_o      // Second cycle
);

  // ==========================================================================
  // Condition
  // ==========================================================================
  logic cond;

  cbu_cond u_cond (
    .kind_i   (kind_i),
    .sel_i    (sel_i),
    .status_i (status_i),
    .taken_o  (cond)
  );

  function automatic logic [PC_W-1:0] target(input logic [PC_W-1:0] pc,
                                             input logic [DISP_W-1:0] k);
    logic [PC_W-1:0] k_ext;
    k_ext  = PC_W'($signed(k));
    target = PC_W'(pc + k_ext + PC_W'(1));
  endfunction

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  cbu_pkg::cbu_state_t state_q, state_d;
  logic [PC_W-1:0]     pc_q, pc_d;
  logic                load_q, load_d;
  logic                taken_q, taken_d;
  logic                done_q, done_d;
  logic                busy_q, busy_d;
  logic                go;

  always_comb begin
    // Kinds past the last branch are ignored, like no branch at all
    go      = valid_i && (kind_i != cbu_pkg::CBU_NONE) &&
              (kind_i <= cbu_pkg::CBU_BRANCH_LOWER);
    state_d = state_q;
    pc_d    = pc_q;
    load_d  = 1'b0;
    taken_d = 1'b0;
    done_d  = 1'b0;
    busy_d  = 1'b0;
    case (state_q)
      cbu_pkg::CBU_IDLE: begin
        if (go && cond) begin
          // Taken: target held, busy next cycle, completes the cycle after
          state_d = cbu_pkg::CBU_REDIRECT;
          pc_d    = target(pc_i, disp_i);
          busy_d  = 1'b1;
        end else if (go) begin
          // Not taken: sequential pc, one cycle
          pc_d   = PC_W'(pc_i + PC_W'(1));
          load_d = 1'b1;
          done_d = 1'b1;
        end
      end
      cbu_pkg::CBU_REDIRECT: begin
        state_d = cbu_pkg::CBU_IDLE;
        load_d  = 1'b1;
        taken_d = 1'b1;
        done_d  = 1'b1;
      end
      default: state_d = cbu_pkg::CBU_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= cbu_pkg::CBU_IDLE;
      pc_q    <= PC_W'(cbu_pkg::PC_RESET);
      load_q  <= 1'b0;
      taken_q <= 1'b0;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      load_q  <= load_d;
      taken_q <= taken_d;
      done_q  <= done_d;
      busy_q  <= busy_d;
    end
  end

  // Status register has no write path here
  assign pc_load_o = load_q;
  assign pc_o      = pc_q;
  assign taken_o   = taken_q;
  assign done_o    = done_q;
  assign busy_o    = busy_q;

endmodule

// [cbu_unit_chk.sv]
/* Assertions on cbu_unit: branch decision, timing and target.
   Bound to cbu_unit; sees only its ports. */
`timescale 1ns/1ps
module cbu_unit_chk #(
  parameter int unsigned PC_W   = 13,
  parameter int unsigned DISP_W = 7
) (
  input wire logic                         mclk_i,    // Clock
  input wire logic                         nrst_i,    // Reset, low
  input wire logic                         valid_i,   // Issue
  input wire cbu_pkg::cbu_kind_t           kind_i,    // Kind
  input wire logic [2:0]                   sel_i,     // Select
  input wire logic [DISP_W-1:0]            disp_i,    // Offset
  input wire logic [PC_W-1:0]              pc_i,      // Pc
  input wire logic [cbu_pkg::STATUS_W-1:0] status_i,  // Status
  input wire logic                         pc_load_o, // Load
  input wire logic [PC_W-1:0]              pc_o,      // Next pc
  input wire logic                         taken_o,   // Taken
  input wire logic                         done_o,    // Done
  input wire logic                         busy_o     // Busy
);
  // ==========
  // Decision
  // ==========
  logic            flag;
  logic            cond;
  logic            acc;
  logic [PC_W-1:0] tgt;
  assign flag = (kind_i < 4'h3) ? status_i[sel_i] :
                status_i[(kind_i < 4'h5) ? cbu_pkg::FLAG_Z : cbu_pkg::FLAG_C];
  assign cond = flag ^ (kind_i inside {4'h2, 4'h4, 4'h6, 4'h7});
  assign acc  = valid_i && !busy_o && kind_i != 4'h0 && kind_i < 4'h9;
  assign tgt  = pc_i + PC_W'({{PC_W{disp_i[DISP_W-1]}}, disp_i}) + 1'b1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ==========
  // Properties
  // ==========
  a_fall_through: assert property (acc && !cond |=> pc_load_o && done_o && !taken_o &&
    !busy_o && pc_o == $past(pc_i) + 1'b1) else $error("fall through wrong");
  a_taken_two: assert property (acc && cond |=> busy_o && !pc_load_o ##1
    !busy_o && pc_load_o && taken_o && done_o) else $error("taken timing wrong");
  a_taken_target: assert property (acc && cond |=> pc_o == $past(tgt))
    else $error("taken target wrong");
  a_pc_holds: assert property (!acc |=> $stable(pc_o)) else $error("pc moved");
  a_busy_cause: assert property (busy_o |-> $past(acc && cond)) else $error("stray busy");
  a_load_cause: assert property (pc_load_o |-> $past(busy_o) || $past(acc && !cond))
    else $error("stray load");
  a_taken_only: assert property (taken_o |-> $past(busy_o) && pc_load_o)
    else $error("stray taken");
  a_done_load: assert property (done_o == pc_load_o) else $error("done apart from load");
  c_taken: cover property (acc && cond);
  c_fall: cover property (acc && !cond);
  c_refused: cover property (busy_o && valid_i);
endmodule

bind cbu_unit cbu_unit_chk #(.PC_W(PC_W), .DISP_W(DISP_W)) u_chk (.mclk_i(mclk_i),
  .nrst_i(nrst_i), .valid_i(valid_i), .kind_i(kind_i), .sel_i(sel_i), .disp_i(disp_i),
  .pc_i(pc_i), .status_i(status_i), .pc_load_o(pc_load_o), .pc_o(pc_o),
  .taken_o(taken_o), .done_o(done_o), .busy_o(busy_o));

// [cbu_unit_tb.sv]
/* Testbench for cbu_unit: random branches checked against a cycle model.
   Assumes cbu_pkg and the checker are compiled first. */
`timescale 1ns/1ps
module cbu_unit_tb;
  logic               mclk_i = 1'b0;
  logic               nrst_i = 1'b0;
  logic               valid_i = 1'b0;
  cbu_pkg::cbu_kind_t kind_i = cbu_pkg::CBU_NONE;
  logic [2:0]         sel_i = 3'h0;
  logic [6:0]         disp_i = 7'h00;
  logic [12:0]        pc_i = 13'h0000;
  logic [7:0]         status_i = 8'h00;
  logic               pc_load_o, taken_o, done_o, busy_o, c, acc;
  logic [12:0]        pc_o, m_pc = 13'h0000;
  logic               m_busy = 1'b0, m_load = 1'b0, m_taken = 1'b0;
  logic [15:0]        s = 16'h002c;
  int                 err_count = 0, comparisons = 0;
  always #50 mclk_i = ~mclk_i;
  cbu_unit dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .valid_i(valid_i), .kind_i(kind_i),
    .sel_i(sel_i), .disp_i(disp_i), .pc_i(pc_i), .status_i(status_i),
    .pc_load_o(pc_load_o), .pc_o(pc_o), .taken_o(taken_o), .done_o(done_o), .busy_o(busy_o));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Model and stimulus
  // ==========
  always @(posedge mclk_i) begin
    if (nrst_i) begin
      case (kind_i)
        4'h1: c = status_i[sel_i];
        4'h2: c = !status_i[sel_i];
        4'h3: c = status_i[1];
        4'h4: c = !status_i[1];
        4'h5, 4'h8: c = status_i[0];
        4'h6, 4'h7: c = !status_i[0];
        default: c = 1'b0;
      endcase
      acc = valid_i && !m_busy && kind_i != 4'h0 && kind_i < 4'h9;
      m_load = (acc && !c) || m_busy;
      m_taken = m_busy;
      if (acc) m_pc = pc_i + (c ? {{6{disp_i[6]}}, disp_i} : 13'h0000) + 13'h0001;
      m_busy = acc && c;
      s = lfsr(lfsr(s));
      valid_i <= |s[1:0];
      kind_i <= cbu_pkg::cbu_kind_t'(s[5:2] % 4'ha);
      {sel_i, status_i} <= {s[8:6], s[15:8]};
      s = lfsr(lfsr(lfsr(s)));
      {disp_i, pc_i} <= {s[6:0], s[15:3]};
    end else begin
      m_busy = 1'b0;
      m_load = 1'b0;
      m_taken = 1'b0;
      m_pc = 13'h0000;
    end
  end
  always @(negedge mclk_i) begin
    if (nrst_i) begin
      comparisons++;
      if (pc_load_o !== m_load || done_o !== m_load || taken_o !== m_taken ||
          busy_o !== m_busy || pc_o !== m_pc) begin
        err_count++;
        $display("CHECK FAILED %0t outputs differ from model", $time);
      end
    end
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (1500) @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (1500) @(posedge mclk_i);
    stop_test();
  end
endmodule
